// ==== cdm_consts.svh ====
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define CDM_IDX_CTRL 6'h00
`define CDM_IDX_STAT 6'h01
`define CDM_IDX_DAC2 6'h0c
`define CDM_IDX_MIX1 6'h0d

// ****************************************************************
// field positions, shared by both 16-bit registers
// ****************************************************************
`define CDM_L_MUTE 15
`define CDM_L_ATT_HI 13
`define CDM_L_ATT_LO 8
`define CDM_R_MUTE 7
`define CDM_R_ATT_HI 5
`define CDM_R_ATT_LO 0
`define CDM_FIELD_MASK 16'hbfbf
`define CDM_ATT_MAX 6'h3f

// ****************************************************************
// control and status bits
// ****************************************************************
`define CDM_CTRL_ALL_OFF 0
`define CDM_STAT_BLOCKED 0
`define CDM_STAT_RATE_FAULT 1
`define CDM_STAT_MIX_L_ON 2
`define CDM_STAT_MIX_R_ON 3

// ****************************************************************
// reset values
// ****************************************************************
`define CDM_DAC2_RESET 16'h0000
`define CDM_MIX1_RESET 16'h8080

// ****************************************************************
// gain mantissas for 0, 1.5, 3.0 and 4.5 dB, unsigned q15
// ****************************************************************
`define CDM_MANT0 17'h08000
`define CDM_MANT1 17'h06bb3
`define CDM_MANT2 17'h05a9e
`define CDM_MANT3 17'h04c3f
`define CDM_MANT_SHIFT 5'h0f

`define CDM_RESP_OKAY 2'b00
`define CDM_RESP_SLVERR 2'b10

`endif

// ==== cdm_pkg.sv ====
package cdm_pkg;
   typedef logic signed [15:0] cdm_smp_t;
   typedef enum logic [2:0] {
      CDM_REG_CTRL = 3'b000,
      CDM_REG_STAT = 3'b001,
      CDM_REG_DAC2 = 3'b010,
      CDM_REG_MIX1 = 3'b011,
      CDM_REG_NONE = 3'b100
   } cdm_reg_e;
endpackage : cdm_pkg

// ==== cdm_atten_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface cdm_atten_if;
   logic [5:0] code;
   logic mute;
   logic top_mutes;
   cdm_pkg::cdm_smp_t din;
   cdm_pkg::cdm_smp_t dout;
   modport calc (input code, input mute, input top_mutes, input din, output dout);
   modport user (output code, output mute, output top_mutes, output din, input dout);
endinterface : cdm_atten_if
`default_nettype wire

// ==== cdm_atten.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cdm_consts.svh"
module cdm_atten (
   // sample and setting
   cdm_atten_if.calc att
);
   import cdm_pkg::*;

   logic [16:0] mant;
   logic signed [32:0] prod;
   logic signed [32:0] shf;
   logic [4:0] shamt;

   // ****************************************************************
   // gain = mantissa of code mod 4, halved per 6 dB
   // ****************************************************************
   always_comb begin
      case (att.code[1:0])
         2'h0: mant = `CDM_MANT0;
         2'h1: mant = `CDM_MANT1;
         2'h2: mant = `CDM_MANT2;
         2'h3: mant = `CDM_MANT3;
         default: mant = `CDM_MANT0;
      endcase
   end

   assign shamt = `CDM_MANT_SHIFT + {1'b0, att.code[5:2]};
   // |gain| <= 1, so the low half never overflows
   assign prod = att.din * $signed(mant);
   assign shf = prod >>> shamt;
   // mix paths treat the top code as full mute; the plain path only attenuates
   assign att.dout = (att.mute | (att.top_mutes & (att.code == `CDM_ATT_MAX))) ?
                     16'sh0000 : shf[15:0];
endmodule : cdm_atten
`default_nettype wire

// ==== cdm_regs.sv ====
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cdm_consts.svh"
module cdm_regs (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // device pin
   input wire logic power_down_pin_n,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // sample timing
   input wire logic sample_tick,
   input wire logic conv_tick,
   // samples in
   input wire cdm_pkg::cdm_smp_t dac2_l_in,
   input wire cdm_pkg::cdm_smp_t dac2_r_in,
   input wire cdm_pkg::cdm_smp_t adc_l_in,
   input wire cdm_pkg::cdm_smp_t adc_r_in,
   input wire cdm_pkg::cdm_smp_t dac1_l_in,
   input wire cdm_pkg::cdm_smp_t dac1_r_in,
   // samples out
   output cdm_pkg::cdm_smp_t dac2_l_out,
   output cdm_pkg::cdm_smp_t dac2_r_out,
   output cdm_pkg::cdm_smp_t dac1_l_out,
   output cdm_pkg::cdm_smp_t dac1_r_out,
   output logic out_valid
);
   import cdm_pkg::*;

   // ****************************************************************
   // decoding and arithmetic helpers
   // ****************************************************************
   function automatic cdm_reg_e reg_sel(input logic [7:0] a);
      case (a[7:2])
         `CDM_IDX_CTRL: reg_sel = CDM_REG_CTRL;
         `CDM_IDX_STAT: reg_sel = CDM_REG_STAT;
         `CDM_IDX_DAC2: reg_sel = CDM_REG_DAC2;
         `CDM_IDX_MIX1: reg_sel = CDM_REG_MIX1;
         default: reg_sel = CDM_REG_NONE;
      endcase
   endfunction : reg_sel

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   function automatic cdm_smp_t sat16(input logic signed [16:0] v);
      if (v[16] != v[15]) begin
         sat16 = v[16] ? 16'sh8000 : 16'sh7fff;
      end else begin
         sat16 = v[15:0];
      end
   endfunction : sat16

   // ****************************************************************
   // state
   // ****************************************************************
   logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic all_off_r;
   logic rate_fault_r;
   logic conv_seen_r;
   logic [15:0] dac2_r, mix_r;
   logic [15:0] sh_dac2_r, sh_mix_r;
   cdm_smp_t smp_r [0:5];
   logic proc_r;
   cdm_smp_t att_out [0:3];
   cdm_smp_t dac2_l_r, dac2_r_r, dac1_l_r, dac1_r_r;
   logic out_valid_r;

   logic aw_hs, w_hs, ar_hs, aw_have, w_have, wr_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   cdm_reg_e wsel;
   logic blocked;
   logic mix_l_on, mix_r_on;
   logic [31:0] rd_word;

   // ****************************************************************
   // axi4-lite handshakes
   // ****************************************************************
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign aw_have = aw_held_r || aw_hs;
   assign w_have = w_held_r || w_hs;
   assign wr_fire = aw_have && w_have && !bvalid_r;
   assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
   assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
   assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
   assign wsel = reg_sel(wr_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r <= 8'h00;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end else if (aw_hs) begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end else if (w_hs) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `CDM_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wsel == CDM_REG_NONE) ? `CDM_RESP_SLVERR : `CDM_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // the disable bit must stay writable, else the block could never recover
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         all_off_r <= 1'b0;
      end else if (wr_fire && wsel == CDM_REG_CTRL && wr_strb[0]) begin
         all_off_r <= wr_data[`CDM_CTRL_ALL_OFF];
      end
   end

   assign blocked = !power_down_pin_n || all_off_r;

   always_ff @(posedge aclk) begin
      if (!aresetn || blocked) begin
         dac2_r <= `CDM_DAC2_RESET;
      end else if (wr_fire && wsel == CDM_REG_DAC2) begin
         dac2_r <= merge16(dac2_r, wr_data, wr_strb) & `CDM_FIELD_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || blocked) begin
         mix_r <= `CDM_MIX1_RESET;
      end else if (wr_fire && wsel == CDM_REG_MIX1) begin
         mix_r <= merge16(mix_r, wr_data, wr_strb) & `CDM_FIELD_MASK;
      end
   end

   // ****************************************************************
   // frame rate check while mixing
   // ****************************************************************
   assign mix_l_on = !mix_r[`CDM_L_MUTE] &&
                     (mix_r[`CDM_L_ATT_HI:`CDM_L_ATT_LO] != `CDM_ATT_MAX);
   assign mix_r_on = !mix_r[`CDM_R_MUTE] &&
                     (mix_r[`CDM_R_ATT_HI:`CDM_R_ATT_LO] != `CDM_ATT_MAX);

   always_ff @(posedge aclk) begin
      if (!aresetn || sample_tick) begin
         conv_seen_r <= 1'b0;
      end else if (conv_tick) begin
         conv_seen_r <= 1'b1;
      end
   end

   // two conversions with no frame between means frames are too slow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rate_fault_r <= 1'b0;
      end else if (conv_tick && conv_seen_r && !sample_tick && (mix_l_on || mix_r_on)) begin
         rate_fault_r <= 1'b1;
      end else if (wr_fire && wsel == CDM_REG_STAT && wr_strb[0] &&
                   wr_data[`CDM_STAT_RATE_FAULT]) begin
         rate_fault_r <= 1'b0;
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   always_comb begin
      rd_word = 32'h0000_0000;
      case (reg_sel(s_axi_araddr))
         CDM_REG_CTRL: rd_word[`CDM_CTRL_ALL_OFF] = all_off_r;
         CDM_REG_STAT: begin
            rd_word[`CDM_STAT_BLOCKED] = blocked;
            rd_word[`CDM_STAT_RATE_FAULT] = rate_fault_r;
            rd_word[`CDM_STAT_MIX_L_ON] = mix_l_on;
            rd_word[`CDM_STAT_MIX_R_ON] = mix_r_on;
         end
         CDM_REG_DAC2: rd_word[15:0] = dac2_r;
         CDM_REG_MIX1: rd_word[15:0] = mix_r;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `CDM_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= (reg_sel(s_axi_araddr) == CDM_REG_NONE) ? `CDM_RESP_SLVERR :
                    `CDM_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ****************************************************************
   // sample capture and settings shadow
   // ****************************************************************
   // settings are sampled once per frame so a sample never sees half an update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh_dac2_r <= `CDM_DAC2_RESET;
         sh_mix_r <= `CDM_MIX1_RESET;
         proc_r <= 1'b0;
         for (int k = 0; k < 6; k++) begin
            smp_r[k] <= 16'sh0000;
         end
      end else begin
         proc_r <= sample_tick;
         if (sample_tick) begin
            sh_dac2_r <= dac2_r;
            sh_mix_r <= mix_r;
            smp_r[0] <= dac2_l_in;
            smp_r[1] <= dac2_r_in;
            smp_r[2] <= adc_l_in;
            smp_r[3] <= adc_r_in;
            smp_r[4] <= dac1_l_in;
            smp_r[5] <= dac1_r_in;
         end
      end
   end

   // ****************************************************************
   // attenuators: 0,1 out2 left/right, 2,3 mix left/right
   // ****************************************************************
   cdm_atten_if att_if [4] ();

   generate
      for (genvar i = 0; i < 4; i++) begin : g_att
         logic [15:0] src;
         assign src = (i < 2) ? sh_dac2_r : sh_mix_r;
         assign att_if[i].code = (i % 2 == 0) ? src[`CDM_L_ATT_HI:`CDM_L_ATT_LO] :
                                 src[`CDM_R_ATT_HI:`CDM_R_ATT_LO];
         assign att_if[i].mute = (i % 2 == 0) ? src[`CDM_L_MUTE] : src[`CDM_R_MUTE];
         assign att_if[i].top_mutes = (i >= 2);
         assign att_if[i].din = smp_r[i];
         assign att_out[i] = att_if[i].dout;
         cdm_atten u_att (
            .att(att_if[i])
         );
      end
   endgenerate

   // ****************************************************************
   // output stage
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac2_l_r <= 16'sh0000;
         dac2_r_r <= 16'sh0000;
         dac1_l_r <= 16'sh0000;
         dac1_r_r <= 16'sh0000;
         out_valid_r <= 1'b0;
      end else begin
         out_valid_r <= proc_r;
         if (proc_r) begin
            dac2_l_r <= att_out[0];
            dac2_r_r <= att_out[1];
            dac1_l_r <= sat16({smp_r[4][15], smp_r[4]} + {att_out[2][15], att_out[2]});
            dac1_r_r <= sat16({smp_r[5][15], smp_r[5]} + {att_out[3][15], att_out[3]});
         end
      end
   end

   assign dac2_l_out = dac2_l_r;
   assign dac2_r_out = dac2_r_r;
   assign dac1_l_out = dac1_l_r;
   assign dac1_r_out = dac1_r_r;
   assign out_valid = out_valid_r;

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_out2_mute: assert property (
      @(posedge aclk) disable iff (!aresetn)
      proc_r && sh_dac2_r[`CDM_L_MUTE] |=> dac2_l_out == 16'sh0000)
      else $error("muted out2 left channel not zero");

   a_out2_unity: assert property (
      @(posedge aclk) disable iff (!aresetn)
      proc_r && !sh_dac2_r[`CDM_R_MUTE] && sh_dac2_r[`CDM_R_ATT_HI:`CDM_R_ATT_LO] == 6'h00
      |=> dac2_r_out == $past(smp_r[1]))
      else $error("out2 code zero did not pass sample unchanged");

   a_dac2_default: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !power_down_pin_n ##1 !power_down_pin_n |-> dac2_r == `CDM_DAC2_RESET)
      else $error("out2 register not at default while powered down");

   a_write_blocked: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_fire && blocked |=> mix_r == `CDM_MIX1_RESET && dac2_r == `CDM_DAC2_RESET)
      else $error("write accepted while blocked");

   a_mix_layout: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_fire && !blocked && wsel == CDM_REG_MIX1 && wr_strb == 4'hf
      |=> mix_r == ($past(wr_data[15:0]) & `CDM_FIELD_MASK))
      else $error("mix register write does not match field layout");

   a_mix_mute_bit: assert property (
      @(posedge aclk) disable iff (!aresetn)
      proc_r && sh_mix_r[`CDM_L_MUTE] |=> dac1_l_out == $past(smp_r[4]))
      else $error("muted mix still altered dac1 left");

   a_mix_full_mute: assert property (
      @(posedge aclk) disable iff (!aresetn)
      proc_r && sh_mix_r[`CDM_R_ATT_HI:`CDM_R_ATT_LO] == `CDM_ATT_MAX
      |=> dac1_r_out == $past(smp_r[5]))
      else $error("top mix code did not fully mute");

   a_mix_default: assert property (
      @(posedge aclk)
      !aresetn |=> mix_r == `CDM_MIX1_RESET && sh_mix_r == `CDM_MIX1_RESET)
      else $error("mix register reset value wrong");

   a_rate_fault: assert property (
      @(posedge aclk) disable iff (!aresetn)
      conv_tick && conv_seen_r && !sample_tick && (mix_l_on || mix_r_on) |=> rate_fault_r)
      else $error("slow frames while mixing not flagged");

   a_sum_saturates: assert property (
      @(posedge aclk) disable iff (!aresetn)
      proc_r && smp_r[4] == 16'sh7fff && !att_out[2][15] |=> dac1_l_out == 16'sh7fff)
      else $error("dac1 left sum wrapped instead of saturating");

   a_shadow_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !sample_tick |=> $stable(sh_mix_r) && $stable(sh_dac2_r))
      else $error("settings changed between sample boundaries");

endmodule : cdm_regs
`default_nettype wire

// ==== test_dac_atten_adc_mix_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cdm_consts.svh"
module test_dac_atten_adc_mix_regs;
   import cdm_pkg::*;
   typedef struct {logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp;} cdm_row_s;
   localparam logic [7:0] A_CTRL = {`CDM_IDX_CTRL, 2'b00};
   localparam logic [7:0] A_STAT = {`CDM_IDX_STAT, 2'b00};
   localparam logic [7:0] A_DAC2 = {`CDM_IDX_DAC2, 2'b00};
   localparam logic [7:0] A_MIX1 = {`CDM_IDX_MIX1, 2'b00};
   logic aclk = 0, aresetn = 0, pd_n = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, sample_tick = 0, conv_tick = 0;
   logic awready, wready, bvalid, arready, rvalid, out_valid;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [1:0] bresp, rresp, rsp;
   cdm_smp_t s_in [6];
   cdm_smp_t d2l, d2r, d1l, d1r;
   int fail_count = 0, samples_checked = 0;
   cdm_row_s rows [4];
   cdm_regs u_dut (.aclk(aclk), .aresetn(aresetn), .power_down_pin_n(pd_n),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sample_tick(sample_tick),
      .conv_tick(conv_tick), .dac2_l_in(s_in[0]), .dac2_r_in(s_in[1]),
      .adc_l_in(s_in[2]), .adc_r_in(s_in[3]), .dac1_l_in(s_in[4]), .dac1_r_in(s_in[5]),
      .dac2_l_out(d2l), .dac2_r_out(d2r), .dac1_l_out(d1l), .dac1_r_out(d1r),
      .out_valid(out_valid));
   initial begin
      forever #20 aclk = ~aclk;
   end
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic timed_out();
      fail_count++;
      $display("BAD handshake timeout");
      finish_test();
   endtask : timed_out
   // handshakes judged at the falling edge, released by nba after the rising one
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_t, w_t, b_t, done;
      done = 0;
      @(posedge aclk);
      awvalid <= 1;
      awaddr <= a;
      wvalid <= 1;
      wdata <= d;
      bready <= 1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge aclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid && bready;
         r = bresp;
         @(posedge aclk);
         if (aw_t) awvalid <= 0;
         if (w_t) wvalid <= 0;
         if (b_t) begin
            bready <= 0;
            done = 1;
         end
      end
      if (!done) timed_out();
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_t, r_t, done;
      done = 0;
      @(posedge aclk);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge aclk);
         ar_t = arvalid && arready;
         r_t = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar_t) arvalid <= 0;
         if (r_t) begin
            rready <= 0;
            done = 1;
         end
      end
      if (!done) timed_out();
   endtask : axi_read
   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      axi_write(a, d, rsp);
      check("bresp", {30'h0, rsp}, {30'h0, `CDM_RESP_OKAY});
   endtask : wr_ok
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, rd, rsp);
      check(name, rd, exp);
   endtask : rd_chk
   // one frame: six inputs, a tick, then wait for the outputs to turn over
   task automatic frame(input logic [95:0] v);
      logic got;
      int lat;
      got = 0;
      lat = 0;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) s_in[i] <= v[95-16*i -: 16];
      // one frame per conversion keeps the frame rate up with the converters
      sample_tick <= 1;
      conv_tick <= 1;
      @(posedge aclk);
      sample_tick <= 0;
      conv_tick <= 0;
      for (int n = 0; n < 10 && !got; n++) begin
         @(negedge aclk);
         got = out_valid;
         lat = n;
      end
      if (!got) timed_out();
      // outputs turn over one compute cycle after the captured boundary
      check("out_valid latency", lat, 32'h00000001);
   endtask : frame
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      for (int i = 0; i < 6; i++) s_in[i] = 16'h0000;
      rows[0] = '{A_DAC2, 32'hffffffff, 32'h0000bfbf};
      rows[1] = '{A_DAC2, 32'h00003f00, 32'h00003f00};
      rows[2] = '{A_MIX1, 32'h00003f3e, 32'h00003f3e};
      rows[3] = '{A_MIX1, 32'h00008000, 32'h00008000};
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd_chk("dac2 reset", A_DAC2, 32'h00000000);
      rd_chk("mix1 reset", A_MIX1, 32'h00008080);
      foreach (rows[i]) begin
         wr_ok(rows[i].addr, rows[i].wdata);
         rd_chk("field map", rows[i].addr, rows[i].exp);
      end
      $display("test field map done");
      // right pass at code 0, left code 8 is two whole 6 dB shifts
      wr_ok(A_DAC2, 32'h00000800);
      wr_ok(A_MIX1, 32'h00008080);
      frame({16'h1234, 16'h1000, 16'h4000, 16'h4000, 16'h0100, 16'hff00});
      check("dac2 left", {16'h0, d2l[15:0]}, 32'h0000048d);
      check("dac2 right", {16'h0, d2r[15:0]}, 32'h00001000);
      check("mix muted l", {16'h0, d1l[15:0]}, 32'h00000100);
      check("mix muted r", {16'h0, d1r[15:0]}, 32'h0000ff00);
      wr_ok(A_DAC2, 32'h00008080);
      wr_ok(A_MIX1, 32'h0000003f);
      frame({16'h1234, 16'h1000, 16'h7000, 16'h4000, 16'h7fff, 16'h0123});
      check("dac2 mute l", {16'h0, d2l[15:0]}, 32'h00000000);
      check("dac2 mute r", {16'h0, d2r[15:0]}, 32'h00000000);
      check("mix saturate", {16'h0, d1l[15:0]}, 32'h00007fff);
      check("mix code 3f", {16'h0, d1r[15:0]}, 32'h00000123);
      // two conversions with no frame between while the left mix is on
      @(posedge aclk);
      conv_tick <= 1;
      repeat (2) @(posedge aclk);
      conv_tick <= 0;
      rd_chk("rate fault", A_STAT, 32'h00000006);
      wr_ok(A_STAT, 32'h00000002);
      rd_chk("fault cleared", A_STAT, 32'h00000004);
      $display("test datapath done");
      @(posedge aclk);
      pd_n <= 0;
      rd_chk("dac2 pin forced", A_DAC2, 32'h00000000);
      axi_read(A_STAT, rd, rsp);
      check("blocked flag", rd & 32'h1, 32'h00000001);
      wr_ok(A_MIX1, 32'h00000000);
      rd_chk("mix1 pin ignores", A_MIX1, 32'h00008080);
      @(posedge aclk);
      pd_n <= 1;
      rd_chk("mix1 after pin", A_MIX1, 32'h00008080);
      wr_ok(A_CTRL, 32'h00000001);
      wr_ok(A_DAC2, 32'h00000101);
      rd_chk("dac2 off ignores", A_DAC2, 32'h00000000);
      wr_ok(A_CTRL, 32'h00000000);
      wr_ok(A_DAC2, 32'h00000101);
      rd_chk("dac2 after off", A_DAC2, 32'h00000101);
      $display("test blocking done");
      axi_write(8'hfc, 32'h00000001, rsp);
      check("unmapped bresp", {30'h0, rsp}, {30'h0, `CDM_RESP_SLVERR});
      axi_read(8'hfc, rd, rsp);
      check("unmapped rresp", {30'h0, rsp}, {30'h0, `CDM_RESP_SLVERR});
      check("unmapped rdata", rd, 32'h00000000);
      $display("test unmapped done");
      wr_ok(A_MIX1, 32'h0000003f);
      @(posedge aclk);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd_chk("dac2 rereset", A_DAC2, 32'h00000000);
      rd_chk("mix1 rereset", A_MIX1, 32'h00008080);
      $display("test second reset done");
      finish_test();
   end
endmodule : test_dac_atten_adc_mix_regs
`default_nettype wire
